// ---- rtl/fp_format_converter.sv ----
// Operation
// - To-double converts source format to double, rounds by mode, writes target.
// - To-double from single or word is exact; never flags inexact.
// - To-long converts source to 64-bit integer, rounded by current mode.
// - To-long flags invalid on infinity, NaN or result outside 64-bit range.
// - Invalid to-long traps without write if enabled, else writes 2^63-1.
// - Pair pack puts first single high, second single low.
// - Outside 16-register mode, pair pack is a plain move raising no exception condition.
// - To-single converts source to single, rounds by mode, writes target.
// - Lower extract copies source bits 31..0 as a single.
// - Upper extract copies source bits 63..32 as a single.
// - Outside 16-register mode, both extracts are plain moves raising no exception condition.
// - To-single may raise five conditions; to-long only inexact, invalid and unimplemented.
// - Coprocessor unusable and reserved encodings raise their own exceptions.
// - To-word uses 32-bit range, same invalid handling, default 2^31-1.
`timescale 1ns/10ps
`default_nettype none

module fp_format_converter
	import fp_conv_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	input  wire logic        req_valid,
	input  wire logic [2:0]  req_op,
	input  wire logic [1:0]  req_fmt,
	input  wire logic [63:0] src_a,
	input  wire logic [63:0] src_b,
	input  wire logic [4:0]  target_reg_field,
	input  wire logic        cop_usable,
	input  wire logic        fr16_mode,
	input  wire logic [4:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic             res_valid,
	output logic [63:0]      res_data,
	output logic [4:0]       res_reg,
	output logic             exc_valid,
	output logic [1:0]       exc_code,
	output logic [31:0]      reg_rdata
);

	////////////////////////////////////////////////////////////////////////
	// Rounding helpers
	function automatic logic [6:0] lead_zeros(input logic [63:0] v);
		logic [6:0] n;
		logic       hit;
		n = 7'd64;
		hit = 1'b0;
		for (int i = 63; i >= 0; i--) begin
			if (!hit && v[i]) begin
				n = 7'(63 - i);
				hit = 1'b1;
			end
		end
		return n;
	endfunction

	function automatic logic round_inc(input logic [1:0] rm, input logic sgn,
		input logic g, input logic st, input logic lsb);
		logic r;
		case (rm)
			RM_NEAREST: r = g & (st | lsb);
			RM_ZERO:    r = 1'b0;
			RM_UP:      r = ~sgn & (g | st);
			default:    r = sgn & (g | st);
		endcase
		return r;
	endfunction

	// Returns {overflow, underflow, inexact, result}
	function automatic logic [66:0] round_flt(input logic sgn,
		input logic signed [12:0] e, input logic [63:0] m,
		input logic dbl, input logic [1:0] rm);
		logic [6:0]         p;
		logic signed [12:0] emin;
		logic signed [12:0] bias;
		logic signed [12:0] shv;
		logic signed [12:0] ebase;
		logic [10:0]        maxe;
		logic [127:0]       wide;
		logic [64:0]        kept2;
		logic [63:0]        mag;
		logic [63:0]        expf;
		logic               tiny;
		logic               g;
		logic               st;
		logic               ovf;
		logic               inx;
		logic               tozero;
		p = dbl ? DBL_PREC : SGL_PREC;
		emin = dbl ? DBL_EMIN : SGL_EMIN;
		bias = dbl ? DBL_BIAS : SGL_BIAS;
		maxe = dbl ? DBL_EMAX : SGL_EMAX;
		tiny = e < emin;
		// Subnormal results shift further right, folding lost bits into sticky
		shv = 13'sd64 - $signed({6'h0, p}) + (tiny ? emin - e : 13'sd0);
		if (shv > 13'sd100)
			shv = 13'sd100;
		wide = {m, 64'h0} >> shv[6:0];
		g = wide[63];
		st = |wide[62:0];
		kept2 = {1'b0, wide[127:64]} +
			{64'h0, round_inc(rm, sgn, g, st, wide[64])};
		ebase = tiny ? 13'sd0 : e + bias - 13'sd1;
		// Hidden bit and rounding carry ripple straight into the exponent
		mag = ({51'h0, ebase} << (p - 7'd1)) + kept2[63:0];
		expf = mag >> (p - 7'd1);
		ovf = expf >= {53'h0, maxe};
		tozero = (rm == RM_ZERO) | ((rm == RM_UP) & sgn) | ((rm == RM_DOWN) & ~sgn);
		if (ovf)
			mag = ({53'h0, maxe} << (p - 7'd1)) - {63'h0, tozero};
		inx = g | st | ovf;
		return {ovf, tiny & inx, inx,
			dbl ? {sgn, mag[62:0]} : {32'h0, sgn, mag[30:0]}};
	endfunction

	// Returns {invalid, inexact, result}
	function automatic logic [65:0] round_int(input logic sgn,
		input logic signed [12:0] e, input logic [63:0] m,
		input logic lng, input logic [1:0] rm);
		logic signed [12:0] shv;
		logic [127:0]       wide;
		logic [64:0]        kept2;
		logic [64:0]        lim;
		logic [63:0]        sv;
		logic               g;
		logic               st;
		logic               inv;
		shv = 13'sd63 - e;
		if (shv < 13'sd0)
			shv = 13'sd0;
		if (shv > 13'sd100)
			shv = 13'sd100;
		wide = {m, 64'h0} >> shv[6:0];
		g = wide[63];
		st = |wide[62:0];
		kept2 = {1'b0, wide[127:64]} +
			{64'h0, round_inc(rm, sgn, g, st, wide[64])};
		lim = lng ? {1'b0, LONG_DEFAULT} + {64'h0, sgn} :
			{33'h0, WORD_DEFAULT} + {64'h0, sgn};
		inv = (e > 13'sd63) | (kept2 > lim);
		sv = sgn ? (~kept2[63:0]) + 64'h1 : kept2[63:0];
		if (inv)
			sv = lng ? LONG_DEFAULT : {32'h0, WORD_DEFAULT};
		else if (!lng)
			sv = {32'h0, sv[31:0]};
		return {inv, ~inv & (g | st), sv};
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Reset release
	logic rst_meta_q;
	logic rst_n_q;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta_q <= 1'b0;
			rst_n_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_n_q <= rst_meta_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Source decode
	logic [31:0]        fp_control_status_reg_q;
	logic [1:0]         rm;
	logic [4:0]         enables;
	logic               s_sgn;
	logic               s_nan;
	logic               s_snan;
	logic               s_inf;
	logic signed [12:0] s_exp;
	logic [63:0]        s_raw;
	logic [63:0]        s_man;
	logic [6:0]         s_lz;
	logic [63:0]        s_mag;
	src_fmt_e           fmt;
	conv_op_e           op;

	assign fmt = src_fmt_e'(req_fmt);
	assign op = conv_op_e'(req_op);
	assign rm = fp_control_status_reg_q[RM_LSB +: 2];
	assign enables = fp_control_status_reg_q[ENABLE_LSB +: 5];

	always_comb begin
		s_sgn = 1'b0;
		s_nan = 1'b0;
		s_snan = 1'b0;
		s_inf = 1'b0;
		s_exp = 13'sd0;
		s_raw = 64'h0;
		s_mag = 64'h0;
		unique case (fmt)
			FMT_SINGLE: begin
				s_sgn = src_a[31];
				s_nan = (&src_a[30:23]) & (|src_a[22:0]);
				s_snan = s_nan & ~src_a[22];
				s_inf = (&src_a[30:23]) & ~(|src_a[22:0]);
				s_raw = {|src_a[30:23], src_a[22:0], 40'h0};
				s_exp = (|src_a[30:23]) ? $signed({5'h0, src_a[30:23]}) - SGL_BIAS :
					SGL_EMIN;
			end
			FMT_DOUBLE: begin
				s_sgn = src_a[63];
				s_nan = (&src_a[62:52]) & (|src_a[51:0]);
				s_snan = s_nan & ~src_a[51];
				s_inf = (&src_a[62:52]) & ~(|src_a[51:0]);
				s_raw = {|src_a[62:52], src_a[51:0], 11'h0};
				s_exp = (|src_a[62:52]) ? $signed({2'h0, src_a[62:52]}) - DBL_BIAS :
					DBL_EMIN;
			end
			FMT_WORD: begin
				s_sgn = src_a[31];
				s_mag = s_sgn ? {32'h0, (~src_a[31:0]) + 32'h1} : {32'h0, src_a[31:0]};
				s_raw = {s_mag[31:0], 32'h0};
				s_exp = 13'sd31;
			end
			FMT_LONG: begin
				s_sgn = src_a[63];
				s_raw = s_sgn ? (~src_a) + 64'h1 : src_a;
				s_exp = 13'sd63;
			end
		endcase
	end

	// Normalise so the leading one sits at bit 63
	assign s_lz = lead_zeros(s_raw);
	assign s_man = s_raw << s_lz[5:0];
	wire signed [12:0] n_exp = s_exp - $signed({6'h0, s_lz});
	wire               s_zero = ~(|s_raw) & ~s_nan & ~s_inf;

	////////////////////////////////////////////////////////////////////////
	// Operation select
	wire [66:0] flt_r = round_flt(s_sgn, n_exp, s_man, op == OP_TO_DOUBLE, rm);
	wire [65:0] int_r = round_int(s_sgn, n_exp, s_man, op == OP_TO_LONG, rm);
	wire        dbl_out = op == OP_TO_DOUBLE;
	wire        to_int = (op == OP_TO_WORD) | (op == OP_TO_LONG);
	wire        to_flt = (op == OP_TO_DOUBLE) | (op == OP_TO_SINGLE);
	wire        pair_op = (op == OP_PAIR_PACK) | (op == OP_PAIR_LOWER) |
		(op == OP_PAIR_UPPER);
	wire        exact_src = (fmt == FMT_SINGLE) | (fmt == FMT_WORD);
	// Same-format conversion and integer sources for to-integer are not encodable
	wire        reserved = (op == OP_TO_DOUBLE & fmt == FMT_DOUBLE) |
		(op == OP_TO_SINGLE & fmt == FMT_SINGLE) |
		(to_int & (fmt == FMT_WORD | fmt == FMT_LONG)) |
		(op == OP_PAIR_PACK & fmt != FMT_SINGLE) |
		(req_op == 3'h7);
	// Long and paired work in 16-register mode is refused rather than guessed
	wire        fr16_hazard = fr16_mode & (pair_op | op == OP_TO_LONG |
		(to_flt & fmt == FMT_LONG));
	wire        issue = req_valid & cop_usable & ~reserved;

	logic [63:0] res_d;
	logic [5:0]  cause;

	always_comb begin
		res_d = 64'h0;
		cause = 6'h0;
		if (to_flt) begin
			if (s_nan) begin
				res_d = dbl_out ? DBL_QNAN : {32'h0, SGL_QNAN};
				cause[FL_INVALID] = s_snan;
			end else if (s_inf) begin
				res_d = dbl_out ? {s_sgn, DBL_QNAN[62:52], 52'h0} :
					{32'h0, s_sgn, SGL_QNAN[30:23], 23'h0};
			end else if (s_zero) begin
				res_d = dbl_out ? {s_sgn, 63'h0} : {32'h0, s_sgn, 31'h0};
			end else begin
				res_d = flt_r[63:0];
				cause[FL_INEXACT] = flt_r[64] & ~(dbl_out & exact_src);
				cause[FL_UNDERFLOW] = flt_r[65] & ~dbl_out;
				cause[FL_OVERFLOW] = flt_r[66] & ~dbl_out;
			end
		end else if (to_int) begin
			if (s_nan | s_inf) begin
				res_d = op == OP_TO_LONG ? LONG_DEFAULT : {32'h0, WORD_DEFAULT};
				cause[FL_INVALID] = 1'b1;
			end else begin
				res_d = int_r[63:0];
				cause[FL_INVALID] = int_r[65];
				cause[FL_INEXACT] = int_r[64];
			end
		end else if (op == OP_PAIR_PACK) begin
			res_d = {src_a[31:0], src_b[31:0]};
		end else if (op == OP_PAIR_LOWER) begin
			res_d = {32'h0, src_a[31:0]};
		end else if (op == OP_PAIR_UPPER) begin
			res_d = {32'h0, src_a[63:32]};
		end
		if (fr16_hazard) begin
			res_d = 64'h0;
			cause = 6'h0;
			cause[FL_UNIMPL] = 1'b1;
		end
	end

	// Unimplemented always traps; others trap when enabled
	wire fp_trap = cause[FL_UNIMPL] | (|(cause[4:0] & enables));

	////////////////////////////////////////////////////////////////////////
	// Control and status register
	wire         csr_hit = reg_addr == FP_CONTROL_STATUS_REG_OFFSET;
	wire  [31:0] csr_base = (reg_wr & csr_hit) ? reg_wdata & FP_CONTROL_STATUS_REG_WMASK : fp_control_status_reg_q;
	logic [31:0] fp_control_status_reg_d;

	// Conversion results win over a software write in the same cycle
	always_comb begin
		fp_control_status_reg_d = csr_base;
		if (issue) begin
			fp_control_status_reg_d[CAUSE_LSB +: 6] = cause;
			fp_control_status_reg_d[FLAG_LSB +: 5] = csr_base[FLAG_LSB +: 5] | cause[4:0];
		end
	end

	wire [1:0] exc_d = !cop_usable ? EXC_COP_UNUSABLE :
		reserved ? EXC_RESERVED : fp_trap ? EXC_FP : EXC_NONE;

	logic        res_valid_q;
	logic [63:0] res_data_q;
	logic [4:0]  res_reg_q;
	logic        exc_valid_q;
	logic [1:0]  exc_code_q;
	logic [31:0] rdata_q;

	always_ff @(posedge ref_clk or negedge rst_n_q) begin
		if (!rst_n_q) begin
			fp_control_status_reg_q <= FP_CONTROL_STATUS_REG_RESET;
			res_valid_q <= 1'b0;
			res_data_q <= 64'h0;
			res_reg_q <= 5'h0;
			exc_valid_q <= 1'b0;
			exc_code_q <= EXC_NONE;
			rdata_q <= 32'h0;
		end else begin
			fp_control_status_reg_q <= fp_control_status_reg_d;
			res_valid_q <= issue & ~fp_trap;
			if (issue & ~fp_trap) begin
				res_data_q <= res_d;
				res_reg_q <= target_reg_field;
			end
			exc_valid_q <= req_valid & (exc_d != EXC_NONE);
			exc_code_q <= req_valid ? exc_d : EXC_NONE;
			rdata_q <= (reg_rd & csr_hit) ? fp_control_status_reg_q : 32'h0;
		end
	end

	assign res_valid = res_valid_q;
	assign res_data = res_data_q;
	assign res_reg = res_reg_q;
	assign exc_valid = exc_valid_q;
	assign exc_code = exc_code_q;
	assign reg_rdata = rdata_q;

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n_q);

	wire [63:0] pack_expect = {src_a[31:0], src_b[31:0]};
	wire        plain_ok = issue & ~fr16_hazard;

	sequence s_pack_issue;
		plain_ok && op == OP_PAIR_PACK;
	endsequence

	sequence s_bad_long;
		plain_ok && op == OP_TO_LONG && s_inf;
	endsequence

	a_pack_halves: assert property (s_pack_issue |=> res_valid_q &&
		res_data_q == $past(pack_expect))
		else $error("pair pack halves wrong");

	a_pack_quiet: assert property (s_pack_issue |=>
		fp_control_status_reg_q[CAUSE_LSB +: 6] == 6'h0 && !exc_valid_q)
		else $error("pair pack raised a condition");

	a_lower_copy: assert property (plain_ok && op == OP_PAIR_LOWER |=>
		res_data_q[31:0] == $past(src_a[31:0]))
		else $error("lower extract wrong");

	a_upper_copy: assert property (plain_ok && op == OP_PAIR_UPPER |=>
		res_data_q[31:0] == $past(src_a[63:32]))
		else $error("upper extract wrong");

	a_extract_quiet: assert property (plain_ok && (op == OP_PAIR_LOWER ||
		op == OP_PAIR_UPPER) |=> fp_control_status_reg_q[CAUSE_LSB +: 6] == 6'h0 && res_valid_q)
		else $error("extract raised a condition");

	a_double_exact: assert property (issue && op == OP_TO_DOUBLE &&
		exact_src |=> !fp_control_status_reg_q[CAUSE_LSB + FL_INEXACT])
		else $error("exact to-double flagged inexact");

	a_long_trap: assert property (s_bad_long and enables[FL_INVALID] |=>
		exc_valid_q && exc_code_q == EXC_FP && !res_valid_q)
		else $error("enabled invalid did not trap");

	a_long_default: assert property (s_bad_long and !enables[FL_INVALID] |=>
		res_valid_q && res_data_q == LONG_DEFAULT ##0 fp_control_status_reg_q[FLAG_LSB + FL_INVALID])
		else $error("untrapped invalid long wrong");

	a_word_default: assert property (plain_ok && op == OP_TO_WORD && s_nan &&
		!enables[FL_INVALID] |=> res_data_q == {32'h0, WORD_DEFAULT})
		else $error("untrapped invalid word wrong");

	a_invalid_sticky: assert property (fp_control_status_reg_q[FLAG_LSB + FL_INVALID] &&
		!(reg_wr && csr_hit) |=> fp_control_status_reg_q[FLAG_LSB + FL_INVALID])
		else $error("invalid flag lost");

	a_long_no_under: assert property (issue && op == OP_TO_LONG |=>
		!fp_control_status_reg_q[CAUSE_LSB + FL_UNDERFLOW])
		else $error("to-long raised underflow");

	a_cop_unusable: assert property (req_valid && !cop_usable |=>
		exc_valid_q && exc_code_q == EXC_COP_UNUSABLE && !res_valid_q)
		else $error("unusable coprocessor not reported");

endmodule

`default_nettype wire

// ---- rtl/fp_conv_pkg.sv ----
package fp_conv_pkg;

	typedef enum logic [2:0] {
		OP_TO_DOUBLE  = 3'h0,
		OP_TO_SINGLE  = 3'h1,
		OP_TO_WORD    = 3'h2,
		OP_TO_LONG    = 3'h3,
		OP_PAIR_PACK  = 3'h4,
		OP_PAIR_LOWER = 3'h5,
		OP_PAIR_UPPER = 3'h6
	} conv_op_e;

	typedef enum logic [1:0] {
		FMT_SINGLE = 2'h0,
		FMT_DOUBLE = 2'h1,
		FMT_WORD   = 2'h2,
		FMT_LONG   = 2'h3
	} src_fmt_e;

	typedef enum logic [1:0] {
		EXC_NONE         = 2'h0,
		EXC_COP_UNUSABLE = 2'h1,
		EXC_RESERVED     = 2'h2,
		EXC_FP           = 2'h3
	} exc_e;

	localparam logic [1:0] RM_NEAREST = 2'h0;
	localparam logic [1:0] RM_ZERO    = 2'h1;
	localparam logic [1:0] RM_UP      = 2'h2;
	localparam logic [1:0] RM_DOWN    = 2'h3;

	////////////////////////////////////////////////////////////////////////
	localparam logic [4:0]  FP_CONTROL_STATUS_REG_OFFSET = 5'h1F;
	localparam logic [31:0] FP_CONTROL_STATUS_REG_RESET  = 32'h0000_0000;
	localparam logic [31:0] FP_CONTROL_STATUS_REG_WMASK  = 32'h0003_FFFF;
	localparam int RM_LSB     = 0;
	localparam int FLAG_LSB   = 2;
	localparam int ENABLE_LSB = 7;
	localparam int CAUSE_LSB  = 12;
	localparam int FL_INEXACT   = 0;
	localparam int FL_UNDERFLOW = 1;
	localparam int FL_OVERFLOW  = 2;
	localparam int FL_INVALID   = 4;
	localparam int FL_UNIMPL    = 5;

	////////////////////////////////////////////////////////////////////////
	localparam logic [6:0]         SGL_PREC = 7'd24;
	localparam logic [6:0]         DBL_PREC = 7'd53;
	localparam logic signed [12:0] SGL_BIAS = 13'sd127;
	localparam logic signed [12:0] DBL_BIAS = 13'sd1023;
	localparam logic signed [12:0] SGL_EMIN = -13'sd126;
	localparam logic signed [12:0] DBL_EMIN = -13'sd1022;
	localparam logic [10:0]        SGL_EMAX = 11'h0FF;
	localparam logic [10:0]        DBL_EMAX = 11'h7FF;
	localparam logic [31:0] SGL_QNAN = 32'h7FC0_0000;
	localparam logic [63:0] DBL_QNAN = 64'h7FF8_0000_0000_0000;
	localparam logic [63:0] LONG_DEFAULT = 64'h7FFF_FFFF_FFFF_FFFF;
	localparam logic [31:0] WORD_DEFAULT = 32'h7FFF_FFFF;

endpackage

// ---- tb/issue_model.sv ----
`timescale 1ns/10ps
`default_nettype none

module issue_model
	import fp_conv_pkg::*;
(
	input  wire logic   ref_clk,
	output logic        req_valid,
	output logic [2:0]  req_op,
	output logic [1:0]  req_fmt,
	output logic [63:0] src_a,
	output logic [63:0] src_b,
	output logic [4:0]  target_reg_field,
	output logic        cop_usable,
	output logic        fr16_mode
);
	initial begin
		req_valid = 1'b0;
		{req_op, req_fmt, src_a, src_b, target_reg_field} = '0;
		cop_usable = 1'b1;
		fr16_mode = 1'b0;
	end

	// One request per call, launched just after an edge
	task automatic send(input logic [2:0] op, input logic [1:0] fmt, input logic [63:0] a,
		input logic [63:0] b, input logic [4:0] tgt, input logic cop, input logic fr16);
		@(posedge ref_clk);
		req_valid <= 1'b1;
		req_op <= op;
		req_fmt <= fmt;
		src_a <= a;
		src_b <= b;
		target_reg_field <= tgt;
		cop_usable <= cop;
		fr16_mode <= fr16;
	endtask

	// Released operands flip so a stale value is never mistaken for a live one
	task automatic idle();
		@(posedge ref_clk);
		req_valid <= 1'b0;
		src_a <= ~src_a;
		src_b <= ~src_b;
	endtask
endmodule

`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none

module tb_top
	import fp_conv_pkg::*;
;
	typedef struct packed {
		logic [2:0]  op;
		logic [1:0]  fmt;
		logic [1:0]  rm;
		logic [63:0] a;
		logic [63:0] b;
		logic [63:0] res;
		logic [5:0]  cause;
	} row_s;

	logic        ref_clk;
	logic        nrst;
	logic [4:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	wire logic   req_valid;
	wire logic [2:0]  req_op;
	wire logic [1:0]  req_fmt;
	wire logic [63:0] src_a;
	wire logic [63:0] src_b;
	wire logic [4:0]  target_reg_field;
	wire logic   cop_usable;
	wire logic   fr16_mode;
	logic        res_valid;
	logic [63:0] res_data;
	logic [4:0]  res_reg;
	logic        exc_valid;
	logic [1:0]  exc_code;
	logic [31:0] reg_rdata;
	int          miscompares = 0;
	int          checks_done = 0;
	int          cycles = 0;
	row_s        rows [19];

	issue_model i_issue (.ref_clk(ref_clk), .req_valid(req_valid), .req_op(req_op),
		.req_fmt(req_fmt), .src_a(src_a), .src_b(src_b),
		.target_reg_field(target_reg_field), .cop_usable(cop_usable), .fr16_mode(fr16_mode));

	fp_format_converter i_dut (.ref_clk(ref_clk), .nrst(nrst), .req_valid(req_valid),
		.req_op(req_op), .req_fmt(req_fmt), .src_a(src_a), .src_b(src_b),
		.target_reg_field(target_reg_field), .cop_usable(cop_usable), .fr16_mode(fr16_mode),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.res_valid(res_valid), .res_data(res_data), .res_reg(res_reg),
		.exc_valid(exc_valid), .exc_code(exc_code), .reg_rdata(reg_rdata));

	////////////////////////////////////////
	task automatic conclude();
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
		checks_done++;
		if (got !== exp) begin
			$display("wrong value %s expected %h seen %h", name, exp, got);
			miscompares++;
		end
	endtask

	task automatic reg_write(input logic [4:0] addr, input logic [31:0] data);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= addr;
		reg_wdata <= data;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic reg_read(input logic [4:0] addr, output logic [31:0] data);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= addr;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		data = reg_rdata;
	endtask

	task automatic run_op(input logic [2:0] op, input logic [1:0] fmt, input logic [63:0] a,
		input logic [63:0] b, input logic [4:0] tgt, input logic cop, input logic fr16);
		i_issue.send(op, fmt, a, b, tgt, cop, fr16);
		i_issue.idle();
		#1;
	endtask

	task automatic exc_case(input logic [2:0] op, input logic [1:0] fmt, input logic [63:0] a,
		input logic cop, input logic fr16, input logic [1:0] code, input logic [31:0] csr);
		logic [63:0] held;
		logic [31:0] rd;
		held = res_data;
		run_op(op, fmt, a, 64'h0, 5'h1F, cop, fr16);
		chk("exc_valid", 64'h1, {63'h0, exc_valid});
		chk("exc_code", {62'h0, code}, {62'h0, exc_code});
		chk("res_valid", 64'h0, {63'h0, res_valid});
		chk("res_data", held, res_data);
		reg_read(FP_CONTROL_STATUS_REG_OFFSET, rd);
		chk("csr", {32'h0, csr}, {32'h0, rd});
	endtask

	////////////////////////////////////////
	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	// About 165 cycles of work; some eighteen times that means a hang
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			conclude();
		end
	end

	initial begin
		logic [31:0] rd;
		nrst = 1'b0;
		reg_addr = 5'h00;
		reg_wdata = 32'h0000_0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		rows = '{
		'{OP_TO_DOUBLE, FMT_SINGLE, RM_NEAREST, 64'h0000_0000_3F80_0000, 64'h0,
			64'h3FF0_0000_0000_0000, 6'h00},
		'{OP_TO_DOUBLE, FMT_WORD, RM_ZERO, 64'h0000_0000_7FFF_FFFF, 64'h0,
			64'h41DF_FFFF_FFC0_0000, 6'h00},
		'{OP_TO_DOUBLE, FMT_LONG, RM_NEAREST, 64'h0020_0000_0000_0001, 64'h0,
			64'h4340_0000_0000_0000, 6'h01},
		'{OP_TO_SINGLE, FMT_DOUBLE, RM_ZERO, 64'h47F0_0000_0000_0000, 64'h0,
			64'h0000_0000_7F7F_FFFF, 6'h05},
		'{OP_TO_SINGLE, FMT_DOUBLE, RM_NEAREST, 64'h3730_0000_0000_0001, 64'h0,
			64'h0000_0000_0000_0200, 6'h03},
		'{OP_TO_SINGLE, FMT_WORD, RM_UP, 64'h0000_0000_0100_0001, 64'h0,
			64'h0000_0000_4B80_0001, 6'h01},
		'{OP_TO_WORD, FMT_SINGLE, RM_NEAREST, 64'h0000_0000_4020_0000, 64'h0,
			64'h0000_0000_0000_0002, 6'h01},
		'{OP_TO_WORD, FMT_SINGLE, RM_DOWN, 64'h0000_0000_C020_0000, 64'h0,
			64'h0000_0000_FFFF_FFFD, 6'h01},
		'{OP_TO_WORD, FMT_SINGLE, RM_NEAREST, 64'h0000_0000_4F00_0000, 64'h0,
			{32'h0, WORD_DEFAULT}, 6'h10},
		'{OP_TO_WORD, FMT_DOUBLE, RM_ZERO, 64'h41DF_FFFF_FFE0_0000, 64'h0,
			64'h0000_0000_7FFF_FFFF, 6'h01},
		'{OP_TO_LONG, FMT_DOUBLE, RM_NEAREST, 64'hC3E0_0000_0000_0000, 64'h0,
			64'h8000_0000_0000_0000, 6'h00},
		'{OP_TO_LONG, FMT_DOUBLE, RM_NEAREST, 64'h43E0_0000_0000_0000, 64'h0,
			LONG_DEFAULT, 6'h10},
		'{OP_TO_LONG, FMT_DOUBLE, RM_ZERO, 64'h7FF0_0000_0000_0000, 64'h0,
			LONG_DEFAULT, 6'h10},
		'{OP_TO_LONG, FMT_SINGLE, RM_DOWN, 64'h0000_0000_BFC0_0000, 64'h0,
			64'hFFFF_FFFF_FFFF_FFFE, 6'h01},
		'{OP_PAIR_PACK, FMT_SINGLE, RM_NEAREST, 64'h1111_2222_4040_0000,
			64'h3333_4444_7F80_0001, 64'h4040_0000_7F80_0001, 6'h00},
		'{OP_PAIR_LOWER, FMT_DOUBLE, RM_NEAREST, 64'h7F80_0001_FF80_0002, 64'h0,
			64'h0000_0000_FF80_0002, 6'h00},
		'{OP_PAIR_UPPER, FMT_SINGLE, RM_NEAREST, 64'h7F80_0001_FF80_0002, 64'h0,
			64'h0000_0000_7F80_0001, 6'h00},
		'{OP_TO_DOUBLE, FMT_SINGLE, RM_NEAREST, 64'h0000_0000_7F80_0001, 64'h0,
			DBL_QNAN, 6'h10},
		'{OP_TO_WORD, FMT_SINGLE, RM_NEAREST, 64'h0000_0000_7FC0_0000, 64'h0,
			{32'h0, WORD_DEFAULT}, 6'h10}};
		repeat (2) @(posedge ref_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		#1;
		chk("res_valid", 64'h0, {63'h0, res_valid});
		chk("res_data", 64'h0, res_data);
		reg_read(FP_CONTROL_STATUS_REG_OFFSET, rd);
		chk("csr_reset", {32'h0, FP_CONTROL_STATUS_REG_RESET}, {32'h0, rd});
		reg_read(5'h00, rd);
		chk("unmapped", 64'h0, {32'h0, rd});
		// Read data must fall back to zero once the read cycle is over
		@(posedge ref_clk);
		#1;
		chk("rdata_idle", 64'h0, {32'h0, reg_rdata});
		reg_write(FP_CONTROL_STATUS_REG_OFFSET, 32'hFFFF_FFFF);
		reg_write(5'h1E, 32'h0000_0000);
		reg_read(FP_CONTROL_STATUS_REG_OFFSET, rd);
		chk("csr_mask", {32'h0, FP_CONTROL_STATUS_REG_WMASK}, {32'h0, rd});
		for (int i = 0; i < 19; i++) begin
			reg_write(FP_CONTROL_STATUS_REG_OFFSET, {30'h0, rows[i].rm});
			run_op(rows[i].op, rows[i].fmt, rows[i].a, rows[i].b, 5'(i), 1'b1, 1'b0);
			chk("res_valid", 64'h1, {63'h0, res_valid});
			chk("exc_valid", 64'h0, {63'h0, exc_valid});
			chk("res_data", rows[i].res, res_data);
			chk("res_reg", 64'(i), {59'h0, res_reg});
			reg_read(FP_CONTROL_STATUS_REG_OFFSET, rd);
			chk("csr", {46'h0, rows[i].cause, 5'h0, rows[i].cause[4:0], rows[i].rm},
				{32'h0, rd});
		end
		// Hand cases: traps and refusals keep the old result
		reg_write(FP_CONTROL_STATUS_REG_OFFSET, 32'h0000_0800);
		exc_case(OP_TO_LONG, FMT_DOUBLE, 64'h7FF0_0000_0000_0000, 1'b1, 1'b0, EXC_FP,
			32'h0001_0840);
		exc_case(OP_TO_WORD, FMT_SINGLE, 64'h0000_0000_4F00_0000, 1'b1, 1'b0, EXC_FP,
			32'h0001_0840);
		reg_write(FP_CONTROL_STATUS_REG_OFFSET, 32'h0000_0000);
		exc_case(OP_TO_SINGLE, FMT_DOUBLE, 64'h3FF8_0000_0000_0000, 1'b0, 1'b0,
			EXC_COP_UNUSABLE, 32'h0000_0000);
		exc_case(3'h7, FMT_SINGLE, 64'h0, 1'b1, 1'b0, EXC_RESERVED, 32'h0000_0000);
		exc_case(OP_TO_DOUBLE, FMT_DOUBLE, 64'h0, 1'b1, 1'b0, EXC_RESERVED,
			32'h0000_0000);
		exc_case(OP_PAIR_PACK, FMT_DOUBLE, 64'h0, 1'b1, 1'b0, EXC_RESERVED,
			32'h0000_0000);
		exc_case(OP_TO_LONG, FMT_DOUBLE, 64'h3FF0_0000_0000_0000, 1'b1, 1'b1, EXC_FP,
			32'h0002_0000);
		// Back to back: second request launched as the first is taken
		i_issue.send(OP_PAIR_PACK, FMT_SINGLE, 64'h0000_0000_3F80_0000,
			64'h0000_0000_C000_0000, 5'h01, 1'b1, 1'b0);
		i_issue.send(OP_PAIR_UPPER, FMT_SINGLE, 64'hAAAA_5555_0000_0000, 64'h0, 5'h02,
			1'b1, 1'b0);
		#1;
		chk("b2b_first", 64'h3F80_0000_C000_0000, res_data);
		i_issue.idle();
		#1;
		chk("b2b_second", 64'h0000_0000_AAAA_5555, res_data);
		chk("b2b_reg", 64'h2, {59'h0, res_reg});
		conclude();
	end
endmodule

`default_nettype wire
